// >>> core/fqs_ctrl.sv
// Host controller that drives command sequences into an x16 parallel flash.
// Assumes software on APB loads registers, starts one operation, polls busy.
//
// Overview of operation
// - Query entry: one 98H write at 55H, or AAH/55H/98H unlock form.
// - Exit: AAH/55H/F0H unlock form, or single F0H at any address.
// - Command addresses use lines 10..0; upper lines driven to defined zero.
// - Upper data byte ignored by device; driven to zero during commands.
// - Buffer program sends word count minus one, at most 15, then each word.
// - Every buffered word shares address bits 21..4 with the first word.
// - Boundary sectors erased one by one; block erase misses boundary blocks.
// - Password address bits 1..0 pick which 16-bit password part is sent.
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fqs_map.svh"
module fqs_ctrl #(
   parameter int BUF_WORDS = 16
) (
   // Clock and reset
   input  wire logic          CLK,
   input  wire logic          RST,
   // APB slave
   input  wire logic          PSEL,
   input  wire logic          PENABLE,
   input  wire logic          PWRITE,
   input  wire logic [11:0]   PADDR,
   input  wire logic [31:0]   PWDATA,
   output var  logic [31:0]   PRDATA,
   output var  logic          PREADY,
   output var  logic          PSLVERR,
   // Flash pins
   output var  fqs_pkg::fqs_pins_type FLASH_PINS,
   input  wire logic [15:0]   FLASH_DQ_IN
);
   import fqs_pkg::*;

   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_SETUP  = 5'b00010,
      ST_STROBE = 5'b00100,
      ST_HOLD   = 5'b01000,
      ST_RST    = 5'b10000
   } fqs_state_type;

   ////////////////////////////////////////////////////////////////////////////
   // Sequence tables
   function automatic fqs_cyc_type unl(input logic [4:0] k, input logic [15:0] d3);
      fqs_cyc_type c;
      c.rd = 1'b0;
      case (k)
         5'h00:   c = '{addr: `FQS_A_UNLOCK1, data: `FQS_D_UNLOCK1, rd: 1'b0};
         5'h01:   c = '{addr: `FQS_A_UNLOCK2, data: `FQS_D_UNLOCK2, rd: 1'b0};
         default: c = '{addr: `FQS_A_UNLOCK1, data: d3, rd: 1'b0};
      endcase
      return c;
   endfunction : unl

   function automatic logic [4:0] len_of(input fqs_op_type op, input logic [3:0] wc);
      case (op)
         FQS_OP_QLONG, FQS_OP_XLONG, FQS_OP_UCMD: len_of = 5'h03;
         FQS_OP_BUFP:  len_of = 5'(wc) + 5'h06;
         FQS_OP_ERASE: len_of = 5'h06;
         FQS_OP_PASS:  len_of = 5'h04;
         default:      len_of = 5'h01;
      endcase
   endfunction : len_of

   function automatic fqs_cyc_type step_of(input fqs_op_type op, input logic [4:0] k,
                                           input logic [4:0] last, input logic [21:0] a,
                                           input logic [15:0] d, input logic [7:0] c1,
                                           input logic [7:0] c2, input logic [3:0] wc,
                                           input logic blk, input logic [15:0] bw);
      fqs_cyc_type s;
      logic [21:0] ea;
      logic [21:0] ba;
      s  = '{addr: 22'h00_0000, data: 16'h0000, rd: 1'b0};
      ea = blk ? {a[21:15], 15'h0000} : {a[21:12], 12'h000};
      ba = {a[21:4], 4'h0};
      case (op)
         FQS_OP_QSHORT: s = '{addr: `FQS_A_QSHORT, data: `FQS_D_QUERY, rd: 1'b0};
         FQS_OP_QLONG:  s = unl(k, `FQS_D_QUERY);
         FQS_OP_XSHORT: s = '{addr: a, data: `FQS_D_EXIT, rd: 1'b0};
         FQS_OP_XLONG:  s = unl(k, `FQS_D_EXIT);
         FQS_OP_UCMD:   s = unl(k, {8'h00, c1});
         FQS_OP_WRITE:  s = '{addr: a, data: d, rd: 1'b0};
         FQS_OP_READ:   s = '{addr: a, data: 16'h0000, rd: 1'b1};
         FQS_OP_BUFP: begin
            if (k < 5'h02) s = unl(k, 16'h0000);
            else if (k == 5'h02) s = '{addr: ba, data: {8'h00, c1}, rd: 1'b0};
            else if (k == 5'h03) s = '{addr: ba, data: {12'h000, wc}, rd: 1'b0};
            else if (k == last) s = '{addr: ba, data: {8'h00, c2}, rd: 1'b0};
            else s = '{addr: {a[21:4], 4'(k - 5'h04)}, data: bw, rd: 1'b0};
         end
         FQS_OP_ERASE: begin
            if (k < 5'h03) s = unl(k, {8'h00, c1});
            else if (k == 5'h05) s = '{addr: ea, data: {8'h00, c2}, rd: 1'b0};
            else s = unl(k - 5'h03, 16'h0000);
         end
         FQS_OP_PASS:   s = '{addr: {a[21:2], k[1:0]}, data: bw, rd: 1'b0};
         default:       s = '{addr: 22'h00_0000, data: 16'h0000, rd: 1'b0};
      endcase
      return s;
   endfunction : step_of

   ////////////////////////////////////////////////////////////////////////////
   // State
   fqs_state_type state_r, state_nxt;
   fqs_op_type    op_r, op_nxt;
   fqs_pins_type  pins_r, pins_nxt;
   logic [4:0]    k_r, k_nxt, last_r, last_nxt;
   logic [7:0]    cnt_r, cnt_nxt;
   logic [21:0]   addr_r, addr_nxt;
   logic [15:0]   data_r, data_nxt, rdata_r, rdata_nxt;
   logic [31:0]   codes_r, codes_nxt;
   logic          query_r, query_nxt, ident_r, ident_nxt, secid_r, secid_nxt;
   logic          unlk_r, unlk_nxt, sig_r, sig_nxt;
   logic [15:0]   buf_mem [BUF_WORDS];
   logic [15:0]   dq_sync, bw;
   logic [3:0]    widx;
   logic          wr_acc, rd_acc, hit_buf, mapped, done;
   fqs_cyc_type   cur;

   fqs_sync #(.W(16)) u_sync (
      .clk (CLK),
      .rst (RST),
      .d   (FLASH_DQ_IN),
      .q   (dq_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB decode: zero wait, error on unmapped offsets
   assign hit_buf = (PADDR >= `FQS_OFF_BUF_LO) && (PADDR <= `FQS_OFF_BUF_HI);
   assign mapped  = hit_buf || (PADDR <= `FQS_OFF_STATUS);
   assign wr_acc  = PSEL && PENABLE && PWRITE && mapped && (PADDR[1:0] == 2'b00);
   assign rd_acc  = PSEL && !PWRITE;
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && (!mapped || (PADDR[1:0] != 2'b00));

   always_comb begin
      PRDATA = 32'h0000_0000;
      if (rd_acc && PADDR[1:0] == 2'b00) begin
         case (PADDR)
            `FQS_OFF_CTRL:   PRDATA = {28'h000_0000, op_r};
            `FQS_OFF_ADDR:   PRDATA = {10'h000, addr_r};
            `FQS_OFF_DATA:   PRDATA = {16'h0000, data_r};
            `FQS_OFF_RDATA:  PRDATA = {16'h0000, rdata_r};
            `FQS_OFF_CODES:  PRDATA = codes_r;
            `FQS_OFF_STATUS: PRDATA = {26'h000_0000, sig_r, unlk_r, secid_r, ident_r,
                                       query_r, !state_r[0]};
            default:         PRDATA = hit_buf ? {16'h0000, buf_mem[PADDR[5:2]]} : 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequence engine
   assign widx = (op_r == FQS_OP_BUFP) ? 4'(k_r - 5'h04) : k_r[3:0];
   assign bw   = buf_mem[widx];
   assign cur  = step_of(op_r, k_r, last_r, addr_r, data_r,
                         codes_r[`FQS_CODE1_LSB +: 8], codes_r[`FQS_CODE2_LSB +: 8],
                         codes_r[`FQS_WC_LSB +: 4], codes_r[`FQS_BLK_BIT], bw);
   assign done = state_r[3] && cnt_r == 8'h00 && k_r == last_r;

   always_comb begin
      state_nxt = state_r;
      op_nxt    = op_r;
      pins_nxt  = pins_r;
      k_nxt     = k_r;
      last_nxt  = last_r;
      cnt_nxt   = (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
      addr_nxt  = addr_r;
      data_nxt  = data_r;
      codes_nxt = codes_r;
      rdata_nxt = rdata_r;
      query_nxt = query_r;
      ident_nxt = ident_r;
      secid_nxt = secid_r;
      unlk_nxt  = unlk_r;
      sig_nxt   = sig_r;
      // Registers are frozen while busy so a running sequence cannot be broken
      if (wr_acc && state_r == ST_IDLE) begin
         case (PADDR)
            `FQS_OFF_ADDR:  addr_nxt  = PWDATA[21:0];
            `FQS_OFF_DATA:  data_nxt  = PWDATA[15:0];
            `FQS_OFF_CODES: codes_nxt = PWDATA;
            `FQS_OFF_CTRL: begin
               op_nxt = fqs_op_type'(PWDATA[`FQS_CTRL_OP_MSB:0]);
               if (op_nxt == FQS_OP_RESET) begin
                  state_nxt      = ST_RST;
                  cnt_nxt        = 8'(`FQS_RST_CYC);
                  pins_nxt.rst_n = 1'b0;
               end else if (op_nxt != FQS_OP_NONE) begin
                  state_nxt = ST_SETUP;
                  k_nxt     = 5'h00;
                  last_nxt  = len_of(op_nxt, codes_r[`FQS_WC_LSB +: 4]) - 5'h01;
               end
            end
            default: ;
         endcase
      end
      case (state_r)
         ST_IDLE: ;
         ST_SETUP: begin
            pins_nxt.ce_n  = 1'b0;
            pins_nxt.addr  = cur.addr;
            pins_nxt.dq    = cur.data;
            pins_nxt.dq_oe = !cur.rd;
            state_nxt      = ST_STROBE;
            cnt_nxt        = cur.rd ? 8'(`FQS_ACC_CYC) : 8'(`FQS_WP_CYC);
            if (cur.rd) pins_nxt.oe_n = 1'b0;
            else pins_nxt.we_n = 1'b0;
         end
         ST_STROBE: begin
            if (cnt_r == 8'h00) begin
               if (cur.rd) begin
                  rdata_nxt = dq_sync;
                  if (secid_r && cur.addr[7:0] == `FQS_A_LOCK_LOW)
                     unlk_nxt = dq_sync[3];
                  if (query_r && cur.addr >= `FQS_A_SIG0 && cur.addr <= `FQS_A_SIG2)
                     sig_nxt = (cur.addr[1:0] == 2'b00) ? dq_sync == `FQS_D_SIG0 :
                               (cur.addr[1:0] == 2'b01) ? sig_r && dq_sync == `FQS_D_SIG1 :
                               sig_r && dq_sync == `FQS_D_SIG2;
               end
               pins_nxt.we_n = 1'b1;
               pins_nxt.oe_n = 1'b1;
               state_nxt     = ST_HOLD;
               cnt_nxt       = 8'(`FQS_WPH_CYC);
            end
         end
         ST_HOLD: begin
            pins_nxt.ce_n  = 1'b1;
            pins_nxt.dq_oe = 1'b0;
            if (cnt_r == 8'h00) begin
               k_nxt     = k_r + 5'h01;
               state_nxt = (k_r == last_r) ? ST_IDLE : ST_SETUP;
            end
         end
         ST_RST: begin
            if (cnt_r == 8'h00) begin
               pins_nxt.rst_n = 1'b1;
               state_nxt      = ST_IDLE;
               query_nxt      = 1'b0;
               ident_nxt      = 1'b0;
               secid_nxt      = 1'b0;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      if (done) begin
         case (op_r)
            FQS_OP_QSHORT, FQS_OP_QLONG: query_nxt = 1'b1;
            FQS_OP_XSHORT, FQS_OP_XLONG: begin
               query_nxt = 1'b0;
               ident_nxt = 1'b0;
               secid_nxt = 1'b0;
            end
            FQS_OP_UCMD: begin
               if (codes_r[7:0] == `FQS_C_IDENT) ident_nxt = 1'b1;
               if (codes_r[7:0] == `FQS_C_SECID) secid_nxt = 1'b1;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_r <= ST_IDLE;
         op_r    <= FQS_OP_NONE;
         pins_r  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1, dq_oe: 1'b0,
                      addr: `FQS_RST_ADDR, dq: `FQS_RST_DATA};
         k_r     <= 5'h00;
         last_r  <= 5'h00;
         cnt_r   <= 8'h00;
         addr_r  <= `FQS_RST_ADDR;
         data_r  <= `FQS_RST_DATA;
         codes_r <= `FQS_RST_CODES;
         rdata_r <= `FQS_RST_DATA;
         query_r <= 1'b0;
         ident_r <= 1'b0;
         secid_r <= 1'b0;
         unlk_r  <= 1'b0;
         sig_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         op_r    <= op_nxt;
         pins_r  <= pins_nxt;
         k_r     <= k_nxt;
         last_r  <= last_nxt;
         cnt_r   <= cnt_nxt;
         addr_r  <= addr_nxt;
         data_r  <= data_nxt;
         codes_r <= codes_nxt;
         rdata_r <= rdata_nxt;
         query_r <= query_nxt;
         ident_r <= ident_nxt;
         secid_r <= secid_nxt;
         unlk_r  <= unlk_nxt;
         sig_r   <= sig_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Word buffer for buffered program and password data; no reset needed
   always_ff @(posedge CLK) begin
      if (wr_acc && hit_buf && state_r == ST_IDLE)
         buf_mem[PADDR[5:2]] <= PWDATA[15:0];
   end

   assign FLASH_PINS = pins_r;
endmodule : fqs_ctrl
`default_nettype wire

// >>> include/fqs_map.svh
// Constants for the flash query and security-ID command controller.
// Assumes a 100 MHz controller clock and an x16 flash with 22 address lines.
`ifndef FQS_MAP_SVH
`define FQS_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// APB register offsets (byte addresses, one word each)
`define FQS_OFF_CTRL     12'h000
`define FQS_OFF_ADDR     12'h004
`define FQS_OFF_DATA     12'h008
`define FQS_OFF_RDATA    12'h00C
`define FQS_OFF_CODES    12'h010
`define FQS_OFF_STATUS   12'h014
`define FQS_OFF_BUF_LO   12'h040
`define FQS_OFF_BUF_HI   12'h07C

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define FQS_CTRL_OP_MSB  3
`define FQS_CODE1_LSB    0
`define FQS_CODE2_LSB    8
`define FQS_WC_LSB       16
`define FQS_BLK_BIT      20
`define FQS_ST_BUSY      0
`define FQS_ST_QUERY     1
`define FQS_ST_IDENT     2
`define FQS_ST_SECID     3
`define FQS_ST_UNLOCKED  4
`define FQS_ST_SIG_OK    5

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define FQS_RST_CODES    32'h0000_0000
`define FQS_RST_ADDR     22'h00_0000
`define FQS_RST_DATA     16'h0000

////////////////////////////////////////////////////////////////////////////////
// Command addresses and data
`define FQS_A_QSHORT     22'h00_0055
`define FQS_A_UNLOCK1    22'h00_0555
`define FQS_A_UNLOCK2    22'h00_02AA
`define FQS_D_UNLOCK1    16'h00AA
`define FQS_D_UNLOCK2    16'h0055
`define FQS_D_QUERY      16'h0098
`define FQS_D_EXIT       16'h00F0
`define FQS_C_IDENT      8'h90
`define FQS_C_SECID      8'h88
`define FQS_A_LOCK_LOW   8'hFF
`define FQS_A_SIG0       22'h00_0010
`define FQS_A_SIG2       22'h00_0012
`define FQS_D_SIG0       16'h0051
`define FQS_D_SIG1       16'h0052
`define FQS_D_SIG2       16'h0059

////////////////////////////////////////////////////////////////////////////////
// Timing: times in ns, cycle counts derived from the clock period
`define FQS_CLK_NS       10
`define FQS_T_WP_NS      50
`define FQS_T_WPH_NS     30
`define FQS_T_ACC_NS     100
`define FQS_T_RST_NS     500
`define FQS_SYNC_CYC     4
`define FQS_WP_CYC  ((`FQS_T_WP_NS + `FQS_CLK_NS - 1) / `FQS_CLK_NS)
`define FQS_WPH_CYC ((`FQS_T_WPH_NS + `FQS_CLK_NS - 1) / `FQS_CLK_NS)
`define FQS_ACC_CYC ((`FQS_T_ACC_NS + `FQS_CLK_NS - 1) / `FQS_CLK_NS + `FQS_SYNC_CYC)
`define FQS_RST_CYC ((`FQS_T_RST_NS + `FQS_CLK_NS - 1) / `FQS_CLK_NS)

`endif

// >>> include/fqs_pkg.sv
// Types for the flash query and security-ID command controller.
// Assumes fqs_map.svh supplies all numbers except the opcode values set here.
package fqs_pkg;

   typedef enum logic [3:0] {
      FQS_OP_NONE   = 4'h0,
      FQS_OP_QSHORT = 4'h1,
      FQS_OP_QLONG  = 4'h2,
      FQS_OP_XSHORT = 4'h3,
      FQS_OP_XLONG  = 4'h4,
      FQS_OP_UCMD   = 4'h5,
      FQS_OP_WRITE  = 4'h6,
      FQS_OP_READ   = 4'h7,
      FQS_OP_BUFP   = 4'h8,
      FQS_OP_ERASE  = 4'h9,
      FQS_OP_PASS   = 4'hA,
      FQS_OP_RESET  = 4'hB
   } fqs_op_type;

   typedef struct packed {
      logic [21:0] addr;
      logic [15:0] data;
      logic        rd;
   } fqs_cyc_type;

   typedef struct packed {
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        rst_n;
      logic        dq_oe;
      logic [21:0] addr;
      logic [15:0] dq;
   } fqs_pins_type;

endpackage : fqs_pkg

// >>> core/fqs_sync.sv
// Three-stage input synchroniser for flash pins.
// Assumes asynchronous inputs; output follows once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module fqs_sync #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Data
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] s1_r, s2_r, s3_r, q_r;
   logic [W-1:0] q_nxt;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // Stage one is seen only by stage two
         always_comb begin
            q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r  <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r  <= q_nxt;
      end
   end

   assign q = q_r;
endmodule : fqs_sync
`default_nettype wire

// >>> dv/fqs_flash_mdl.sv
// Behavioural x16 flash: decodes command cycles, answers mode reads.
// Assumes controller pins as driven by fqs_ctrl; read latency is acc_ns.
`timescale 1ns/1ps
`default_nettype none
module fqs_flash_mdl (
   // Controller pins
   input  wire fqs_pkg::fqs_pins_type pins,
   // Read data back to the controller
   output var  logic [15:0]           dq
);
   import fqs_pkg::*;
   // Identification values are arbitrary
   localparam logic [15:0] MAKER_CODE = 16'h1234;
   localparam logic [15:0] PART_CODE  = 16'h4321;
   int          acc_ns    = 20;
   int          mode      = 0;
   int          step      = 0;
   logic        lock_open = 1'b1;
   logic [10:0] ca;
   logic [7:0]  cd;
   fqs_cyc_type log_q[$];
   logic [15:0] sec_mem [256];
   ////////////////////////////////////////
   function automatic logic [15:0] rd_word(input logic [21:0] a);
      case (mode)
         1: case (a)
               22'h10:  return 16'h0051;
               22'h11:  return 16'h0052;
               22'h12:  return 16'h0059;
               22'h13:  return 16'h0002;
               22'h15:  return 16'h0040;
               default: return 16'h0000;
            endcase
         2: return (a[21:1] != 0) ? 16'h0000 : (a[0] ? PART_CODE : MAKER_CODE);
         3: if (a[7:0] == 8'hFF) return {12'h000, lock_open, 3'h0};
            else if (a[8]) return sec_mem[a[7:0]];
            else return {13'h03A0, a[2:0]};
         default: return a[15:0] ^ 16'h5A5A;
      endcase
   endfunction : rd_word
   ////////////////////////////////////////
   always @(posedge pins.we_n) begin
      if (!pins.ce_n) begin
         ca = pins.addr[10:0];
         cd = pins.dq[7:0];
         log_q.push_back('{pins.addr, pins.dq, 1'b0});
         if (cd == 8'hF0) begin
            mode = 0;
            step = 0;
         end else if (step == 0 && ca == 11'h055 && cd == 8'h98) mode = 1;
         else if (step == 0 && ca == 11'h555 && cd == 8'hAA) step = 1;
         else if (step == 1 && ca == 11'h2AA && cd == 8'h55) step = 2;
         else if (step == 2 && ca == 11'h555) begin
            step = 0;
            mode = (cd == 8'h98) ? 1 : (cd == 8'h90) ? 2 : (cd == 8'h88) ? 3 : mode;
         end else if (step == 0 && mode == 3 && pins.addr[8] && lock_open)
            sec_mem[pins.addr[7:0]] = sec_mem[pins.addr[7:0]] & pins.dq;
         else step = 0;
      end
   end
   // Hardware reset acts like a fresh power-up
   always @(negedge pins.rst_n) begin
      mode = 0;
      step = 0;
   end
   initial begin
      dq = 16'h0000;
      for (int i = 0; i < 256; i++)
         sec_mem[i] = {8'hC5, 8'(i)};
   end
   // Released bus shows the inverse, so a stale value never passes
   always @(pins.ce_n, pins.oe_n, pins.addr) begin
      dq <= ~dq;
      if (!pins.ce_n && !pins.oe_n)
         dq <= #(acc_ns) rd_word(pins.addr);
   end
endmodule : fqs_flash_mdl
`default_nettype wire

// >>> dv/fqs_ctrl_chk.sv
// Concurrent checks on the flash pins of the command controller.
// Assumes fqs_pkg compiled first; bound into every fqs_ctrl.
`timescale 1ns/1ps
`default_nettype none
module fqs_ctrl_chk (
   // Clock and reset
   input wire logic                  CLK,
   input wire logic                  RST,
   // Flash pins
   input wire fqs_pkg::fqs_pins_type FLASH_PINS
);
   import fqs_pkg::*;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   wire logic        we_n = FLASH_PINS.we_n;
   wire logic [21:0] a    = FLASH_PINS.addr;
   wire logic [15:0] d    = FLASH_PINS.dq;
   ////////////////////////////////////////
   sequence s_cmd(logic [10:0] ad, logic [7:0] dv);
      $fell(we_n) && a[10:0] == ad && d == {8'h00, dv};
   endsequence
   AST_UNLOCK_ORDER: assert property (s_cmd(11'h555, 8'hAA) |-> ##[8:30] s_cmd(11'h2AA, 8'h55))
      else $error("first unlock cycle not followed by the second");
   AST_UNLOCK_UPPER: assert property (s_cmd(11'h2AA, 8'h55) |-> a[21:11] == 11'h000)
      else $error("upper address lines not low on unlock cycle");
   AST_CMD_DATA_HIGH: assert property ($fell(we_n) && a[10:0] == 11'h555 |-> d[15:8] == 8'h00)
      else $error("upper data byte not low on command cycle");
   AST_STROBE_LEN: assert property ($fell(we_n) |-> (!we_n) [*6] ##1 we_n)
      else $error("write strobe not six clocks long");
   AST_STROBE_STABLE: assert property (!we_n && !$fell(we_n) |-> $stable(a) && $stable(d))
      else $error("address or data moved during write strobe");
   AST_WRITE_SELECT: assert property (!we_n |-> !FLASH_PINS.ce_n && FLASH_PINS.dq_oe)
      else $error("write strobe without select and data drive");
   AST_READ_NO_DRIVE: assert property (!FLASH_PINS.oe_n |-> !FLASH_PINS.dq_oe && we_n)
      else $error("controller drives data bus during a read");
   AST_CYCLE_CLOSE: assert property ($rose(we_n) |-> ##[0:2] (FLASH_PINS.ce_n && !FLASH_PINS.dq_oe))
      else $error("cycle not closed after write strobe");
endmodule : fqs_ctrl_chk
bind fqs_ctrl fqs_ctrl_chk chk_u (.CLK(CLK), .RST(RST), .FLASH_PINS(FLASH_PINS));
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench: APB tasks drive fqs_ctrl, flash model on the pins.
// Assumes fqs_map.svh on the include path and the checker bound.
`timescale 1ns/1ps
`default_nettype none
`include "fqs_map.svh"
module tb_top;
   import fqs_pkg::*;
   logic         clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata, rdat;
   logic [15:0]  dq_in;
   fqs_pins_type pins;
   int           err_count = 0;
   int           n_tests   = 0;
   fqs_ctrl #(.BUF_WORDS(16)) dut_u (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .FLASH_PINS(pins), .FLASH_DQ_IN(dq_in));
   fqs_flash_mdl flash_u (.pins(pins), .dq(dq_in));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic op(input logic [21:0] a, input logic [3:0] code);
      apb(1'b1, `FQS_OFF_ADDR, {10'h000, a});
      apb(1'b1, `FQS_OFF_CTRL, {28'h0000000, code});
      do apb(1'b0, `FQS_OFF_STATUS, 32'h0); while (rdat[0] !== 1'b0);
   endtask : op
   task automatic frd(input logic [21:0] a, input logic [15:0] exp);
      op(a, FQS_OP_READ);
      apb(1'b0, `FQS_OFF_RDATA, 32'h0);
      chk(rdat, {16'h0000, exp});
   endtask : frd
   task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
      apb(1'b0, `FQS_OFF_STATUS, 32'h0);
      chk(rdat & mask, exp);
   endtask : stat
   ////////////////////////////////////////
   task automatic t_regs();
      chk({pins.ce_n, pins.oe_n, pins.we_n, pins.rst_n, pins.dq_oe}, 5'h1E);
      apb(1'b0, `FQS_OFF_CODES, 32'h0);
      chk({rerr, rdat}, {1'b0, `FQS_RST_CODES});
      apb(1'b0, 12'h018, 32'h0);
      chk(rerr, 1'b1);
      apb(1'b0, 12'h002, 32'h0);
      chk(rerr, 1'b1);
   endtask : t_regs
   task automatic t_query(input logic [3:0] entry, input logic [3:0] leave, input logic [21:0] xa);
      logic [15:0] tbl [11] = '{16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0040,
                                16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
      op(22'h0, entry);
      for (int i = 0; i < 11; i++)
         frd(22'(i + 16), tbl[i]);
      stat(32'h22, 32'h22);
      op(xa, leave);
      frd(22'h10, 16'h5A4A);
      stat(32'h2, 32'h0);
   endtask : t_query
   task automatic t_ident();
      apb(1'b1, `FQS_OFF_CODES, 32'h90);
      op(22'h0, FQS_OP_UCMD);
      frd(22'h0, flash_u.MAKER_CODE);
      frd(22'h1, flash_u.PART_CODE);
      stat(32'h4, 32'h4);
      op(22'h0, FQS_OP_RESET);
      stat(32'h4, 32'h0);
      frd(22'h0, 16'h5A5A);
   endtask : t_ident
   task automatic t_secid();
      apb(1'b1, `FQS_OFF_CODES, 32'h88);
      op(22'h0, FQS_OP_UCMD);
      frd(22'h3, 16'h1D03);
      frd(22'h105, 16'hC505);
      apb(1'b1, `FQS_OFF_DATA, 32'h0000_0F0F);
      op(22'h105, FQS_OP_WRITE);
      chk({flash_u.log_q[$].addr, flash_u.log_q[$].data}, {22'h00_0105, 16'h0F0F});
      apb(1'b1, `FQS_OFF_DATA, 32'h0000_FFFF);
      op(22'h105, FQS_OP_WRITE);
      frd(22'h105, 16'h0505);
      apb(1'b0, `FQS_OFF_CTRL, 32'h0);
      chk(rdat, 32'h0000_0007);
      apb(1'b0, `FQS_OFF_DATA, 32'h0);
      chk(rdat, 32'h0000_FFFF);
      frd(22'hFF, 16'h0008);
      stat(32'h18, 32'h18);
      op(22'h0, FQS_OP_XLONG);
      stat(32'h8, 32'h0);
   endtask : t_secid
   task automatic t_buf(input int wc);
      for (int i = 0; i <= wc; i++)
         apb(1'b1, 12'(64 + 4 * i), 32'(16'hBEE0 + i));
      apb(1'b1, `FQS_OFF_CODES, {12'h000, 4'(wc), 16'h2925});
      flash_u.log_q.delete();
      op(22'h12_3457, FQS_OP_BUFP);
      chk(flash_u.log_q.size(), wc + 6);
      chk(flash_u.log_q[3].data, wc);
      for (int i = 0; i <= wc; i++)
         chk({flash_u.log_q[4 + i].addr, flash_u.log_q[4 + i].data},
             {22'(22'h12_3450 + i), 16'(16'hBEE0 + i)});
      chk({flash_u.log_q[wc + 5].addr, flash_u.log_q[wc + 5].data},
          {22'h12_3450, 16'h0029});
   endtask : t_buf
   task automatic t_erase(input logic blk, input logic [21:0] exp);
      apb(1'b1, `FQS_OFF_CODES, {11'h000, blk, 20'h03080});
      op(22'h3F_FABC, FQS_OP_ERASE);
      chk(flash_u.log_q[$].addr, exp);
   endtask : t_erase
   task automatic t_pass();
      for (int i = 0; i < 4; i++)
         apb(1'b1, 12'(64 + 4 * i), 32'(16'h1200 + i));
      flash_u.log_q.delete();
      op(22'h00_0ABD, FQS_OP_PASS);
      for (int i = 0; i < 4; i++)
         chk({flash_u.log_q[i].addr, flash_u.log_q[i].data},
             {22'(22'h00_0ABC + i), 16'(16'h1200 + i)});
   endtask : t_pass
   ////////////////////////////////////////
   task automatic give_verdict();
      $display("err_count=%0d n_tests=%0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   // About 2000 clocks of traffic are expected; 60000 means a hang
   initial begin
      #600us;
      err_count++;
      give_verdict();
   end
   initial begin
      rst     = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_query(FQS_OP_QSHORT, FQS_OP_XSHORT, 22'h3F_FFFF);
      flash_u.acc_ns = 90;
      t_query(FQS_OP_QLONG, FQS_OP_XLONG, 22'h0);
      t_ident();
      t_secid();
      t_buf(0);
      t_buf(15);
      t_erase(1'b0, 22'h3F_F000);
      t_erase(1'b1, 22'h3F_8000);
      t_pass();
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
